/* File: core/flash_guard_consts.vh */
// Purpose: Constants for the flash reset and write-protection block.
// Assumes: 20 MHz system clock, times given in nanoseconds.
// Notes: Status bit positions follow the two status registers.
`ifndef FLASH_GUARD_CONSTS_VH
`define FLASH_GUARD_CONSTS_VH
`define CLK_PERIOD_NS 50
`define SOFT_RESET_TIME_NS 28000
`define SOFT_RESET_CYCLES ((`SOFT_RESET_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_PULSE_WIDTH_NS 1000
`define RESET_PULSE_CYCLES ((`RESET_PULSE_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POWERUP_INHIBIT_NS 5000000
`define POWERUP_INHIBIT_CYCLES ((`POWERUP_INHIBIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OP_TIME_NS 10000
`define OP_CYCLES ((`OP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SR1_BUSY 0
`define SR1_WEL 1
`define SR1_BP_LO 2
`define SR1_BP_HI 5
`define SR1_TB 6
`define SR1_STATUS_PROTECT_LO 7
`define SR2_STATUS_PROTECT_HI 0
`define SR2_QE 1
`define SR2_CMP 6
`define SR1_RESET 8'h00
`define SR2_RESET 8'h00
`define OP_WREN 8'h06
`define OP_WRDI 8'h04
`define OP_RDSR1 8'h05
`define OP_RDSR2 8'h35
`define OP_WRSR 8'h01
`define OP_PP 8'h02
`define OP_QPP 8'h32
`define OP_SE 8'h20
`define OP_BE32 8'h52
`define OP_BE64 8'hD8
`define OP_CE 8'hC7
`define OP_ERSEC 8'h44
`define OP_PRSEC 8'h42
`define OP_SUSPEND 8'h75
`define OP_PDOWN 8'hB9
`define OP_RELPD 8'hAB
`define OP_RSTEN 8'h66
`define OP_RST 8'h99
`define OP_QPI_ON 8'h38
`define OP_QPI_OFF 8'hFF
`endif

/* File: core/cmd_shifter.v */
// Purpose: Shifts instruction bytes off the serial link in single-line or four-line mode.
// Assumes: Link clock and select are synchronised already; link clock period far above sys_clk.
// Notes: The first byte after select falls is reported as the opcode; later bytes are reported as payload.
`timescale 1ns/10ps
module cmd_shifter (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Synchronised link
  input wire sck_rise,
  input wire cs_active,
  input wire quad_mode,
  input wire [3:0] io_in,
  input wire hold_active,
  // Decoded instruction
  output reg [7:0] opcode_q,
  output reg opcode_valid_q,
  output reg [7:0] payload_q,
  output reg payload_valid_q
);
  reg [7:0] shift_q;
  reg [3:0] count_q;
  reg first_q;
  wire [7:0] next_shift = quad_mode ? {shift_q[3:0], io_in} : {shift_q[6:0], io_in[0]};
  wire [3:0] last_count = quad_mode ? 4'h1 : 4'h7;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= 8'h00;
      count_q <= 4'h0;
      first_q <= 1'b1;
      opcode_q <= 8'h00;
      opcode_valid_q <= 1'b0;
      payload_q <= 8'h00;
      payload_valid_q <= 1'b0;
    end else begin
      opcode_valid_q <= 1'b0;
      payload_valid_q <= 1'b0;
      if (!cs_active) begin
        count_q <= 4'h0;
        first_q <= 1'b1;
      end else if (sck_rise && !hold_active) begin
        shift_q <= next_shift;
        if (count_q == last_count) begin
          count_q <= 4'h0;
          first_q <= 1'b0;
          if (first_q) begin
            opcode_q <= next_shift;
            opcode_valid_q <= 1'b1;
          end else begin
            payload_q <= next_shift;
            payload_valid_q <= 1'b1;
          end
        end else begin
          count_q <= count_q + 4'h1;
        end
      end
    end
  end
endmodule // cmd_shifter

/* File: core/flash_guard.v */
// Purpose: Reset and write-protection control of a serial flash device.
// Assumes: Link pins are asynchronous to sys_clk and sampled twice before use.
// Notes: Instructions act when select rises; the array itself lives outside.
`timescale 1ns/10ps
`include "flash_guard_consts.vh"
module flash_guard #(
  parameter POWERUP_CYCLES = `POWERUP_INHIBIT_CYCLES,
  parameter OP_CYCLES = `OP_CYCLES,
  parameter [7:0] SR3_RESET = 8'h00
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Serial link pins
  input wire sck,
  input wire cs_n,
  input wire [3:0] io_in,
  input wire wp_n,
  input wire shared_pin_n,
  // Configuration and protection lookup
  input wire hold_reset_select,
  input wire target_protected,
  // Status outputs
  output reg [7:0] status_register_one,
  output reg [7:0] status_register_two,
  output reg write_op_q,
  output reg op_abort_q,
  output reg quad_mode_q,
  output reg power_down_q,
  output reg reset_busy_q
);
  localparam ST_IDLE = 2'b00;
  localparam ST_OP = 2'b01;
  localparam ST_SWRST = 2'b10;
  localparam SRST_CNT = `SOFT_RESET_CYCLES;
  localparam PIN_CNT = `RESET_PULSE_CYCLES;

  reg [1:0] sck_s_q, cs_s_q, wp_s_q, pin_s_q;
  reg [3:0] io_a_q, io_b_q;
  reg sck_prev_q, cs_prev_q;
  reg [1:0] state_q;
  reg [31:0] op_cnt_q;
  reg [31:0] pu_cnt_q;
  reg [15:0] pin_cnt_q;
  reg rst_armed_q;
  reg [7:0] cur_op_q;
  reg got_op_q;
  reg [1:0] pay_cnt_q;
  reg [7:0] pay0_q, pay1_q;
  reg wip_q;
  reg pin_reset_q;
  wire [7:0] opcode;
  wire opcode_valid;
  wire [7:0] payload;
  wire payload_valid;

  // Pause and reset on the shared pin are only meaningful while quad lines are off.
  wire qe = status_register_two[`SR2_QE];
  wire pin_low = !pin_s_q[1] && !qe;
  wire hold_active = pin_low && !hold_reset_select;
  wire reset_pin_low = pin_low && hold_reset_select;
  wire sck_rise = sck_s_q[1] && !sck_prev_q;
  wire cs_active = !cs_s_q[1];
  wire cs_end = cs_s_q[1] && !cs_prev_q;
  wire powerup_inhibit = (pu_cnt_q != 32'h0);

  function is_write_op;
    input [7:0] op;
    begin
      is_write_op = (op == `OP_PP) || (op == `OP_QPP) || (op == `OP_SE) || (op == `OP_BE32) ||
                    (op == `OP_BE64) || (op == `OP_CE) || (op == `OP_ERSEC) || (op == `OP_PRSEC);
    end
  endfunction

  function is_array_op;
    input [7:0] op;
    begin
      is_array_op = (op == `OP_PP) || (op == `OP_QPP) || (op == `OP_SE) || (op == `OP_BE32) ||
                    (op == `OP_BE64) || (op == `OP_CE);
    end
  endfunction

  // Status register writes: protect lo/hi bits, pin only outside quad mode.
  wire srp_lock = status_register_two[`SR2_STATUS_PROTECT_HI] ||
                  (status_register_one[`SR1_STATUS_PROTECT_LO] && !wp_s_q[1] && !quad_mode_q);

  cmd_shifter u_shift (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sck_rise(sck_rise),
    .cs_active(cs_active && !reset_pin_low && !pin_reset_q),
    .quad_mode(quad_mode_q),
    .io_in(io_b_q),
    .hold_active(hold_active),
    .opcode_q(opcode),
    .opcode_valid_q(opcode_valid),
    .payload_q(payload),
    .payload_valid_q(payload_valid)
  );

  // Every link pin passes two flip-flops before anything reads it.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_s_q <= 2'b00;
      cs_s_q <= 2'b11;
      wp_s_q <= 2'b11;
      pin_s_q <= 2'b11;
      io_a_q <= 4'h0;
      io_b_q <= 4'h0;
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sck_s_q <= {sck_s_q[0], sck};
      cs_s_q <= {cs_s_q[0], cs_n};
      wp_s_q <= {wp_s_q[0], wp_n};
      pin_s_q <= {pin_s_q[0], shared_pin_n};
      io_a_q <= io_in;
      io_b_q <= io_a_q;
      sck_prev_q <= sck_s_q[1];
      cs_prev_q <= cs_s_q[1];
    end
  end

  // Pin reset qualifies after the minimum low time and holds until the pin rises.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_cnt_q <= 16'h0000;
      pin_reset_q <= 1'b0;
    end else if (!reset_pin_low) begin
      pin_cnt_q <= 16'h0000;
      pin_reset_q <= 1'b0;
    end else if (pin_cnt_q >= PIN_CNT - 16'h0001) begin
      pin_reset_q <= 1'b1;
    end else begin
      pin_cnt_q <= pin_cnt_q + 16'h0001;
    end
  end

  // Capture the instruction and up to two payload bytes of the current frame.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_op_q <= 8'h00;
      got_op_q <= 1'b0;
      pay_cnt_q <= 2'b00;
      pay0_q <= 8'h00;
      pay1_q <= 8'h00;
    end else if (cs_end || pin_reset_q) begin
      got_op_q <= 1'b0;
      pay_cnt_q <= 2'b00;
    end else begin
      if (opcode_valid) begin
        cur_op_q <= opcode;
        got_op_q <= 1'b1;
      end
      if (payload_valid && pay_cnt_q != 2'b10) begin
        pay_cnt_q <= pay_cnt_q + 2'b01;
        if (pay_cnt_q == 2'b00) begin
          pay0_q <= payload;
        end else begin
          pay1_q <= payload;
        end
      end
    end
  end

  // Main control: execution at select rise, busy timing, resets.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      op_cnt_q <= 32'h0;
      pu_cnt_q <= POWERUP_CYCLES;
      rst_armed_q <= 1'b0;
      wip_q <= 1'b0;
      write_op_q <= 1'b0;
      op_abort_q <= 1'b0;
      quad_mode_q <= 1'b0;
      power_down_q <= 1'b0;
      reset_busy_q <= 1'b0;
      status_register_one <= `SR1_RESET;
      status_register_two <= `SR2_RESET;
    end else begin
      op_abort_q <= 1'b0;
      if (powerup_inhibit) begin
        pu_cnt_q <= pu_cnt_q - 32'h1;
      end
      if (pin_reset_q) begin
        // Volatile state returns to power-on values; writes in flight are cut off.
        state_q <= ST_IDLE;
        op_abort_q <= wip_q || write_op_q;
        wip_q <= 1'b0;
        write_op_q <= 1'b0;
        rst_armed_q <= 1'b0;
        quad_mode_q <= 1'b0;
        power_down_q <= 1'b0;
        reset_busy_q <= 1'b0;
        status_register_one[`SR1_WEL] <= 1'b0;
        status_register_one[`SR1_BUSY] <= 1'b0;
      end else begin
        case (state_q)
          ST_OP: begin
            if (op_cnt_q == 32'h0) begin
              state_q <= ST_IDLE;
              wip_q <= 1'b0;
              write_op_q <= 1'b0;
              status_register_one[`SR1_BUSY] <= 1'b0;
              status_register_one[`SR1_WEL] <= 1'b0;
            end else begin
              op_cnt_q <= op_cnt_q - 32'h1;
            end
            if (cs_end && got_op_q && cur_op_q == `OP_SUSPEND) begin
              // Nothing resumes here, so the write ends and the latch drops as after any write.
              state_q <= ST_IDLE;
              wip_q <= 1'b0;
              write_op_q <= 1'b0;
              status_register_one[`SR1_BUSY] <= 1'b0;
              status_register_one[`SR1_WEL] <= 1'b0;
            end
          end
          ST_SWRST: begin
            if (op_cnt_q == 32'h0) begin
              state_q <= ST_IDLE;
              reset_busy_q <= 1'b0;
            end else begin
              op_cnt_q <= op_cnt_q - 32'h1;
            end
          end
          ST_IDLE: begin
            if (cs_end && got_op_q) begin
              // Any instruction other than reset enable breaks the armed reset.
              rst_armed_q <= (cur_op_q == `OP_RSTEN) && !power_down_q;
              if (power_down_q) begin
                if (cur_op_q == `OP_RELPD) begin
                  power_down_q <= 1'b0;
                end
              end else begin
                case (cur_op_q)
                  `OP_RST: begin
                    if (rst_armed_q) begin
                      state_q <= ST_SWRST;
                      op_cnt_q <= SRST_CNT - 1;
                      reset_busy_q <= 1'b1;
                      quad_mode_q <= 1'b0;
                      status_register_one[`SR1_WEL] <= 1'b0;
                    end
                  end
                  `OP_WREN: begin
                    if (!powerup_inhibit) begin
                      status_register_one[`SR1_WEL] <= 1'b1;
                    end
                  end
                  `OP_WRDI: begin
                    status_register_one[`SR1_WEL] <= 1'b0;
                  end
                  `OP_PDOWN: begin
                    power_down_q <= 1'b1;
                  end
                  `OP_QPI_ON: begin
                    quad_mode_q <= qe;
                  end
                  `OP_QPI_OFF: begin
                    quad_mode_q <= 1'b0;
                  end
                  `OP_WRSR: begin
                    // A locked status write is refused outright: no busy time, latch untouched.
                    if (status_register_one[`SR1_WEL] && !powerup_inhibit && !srp_lock) begin
                      status_register_one[`SR1_BUSY] <= 1'b1;
                      state_q <= ST_OP;
                      op_cnt_q <= OP_CYCLES - 1;
                      if (pay_cnt_q != 2'b00) begin
                        status_register_one[7:2] <= pay0_q[7:2];
                        if (pay_cnt_q == 2'b10) begin
                          // Quad enable cannot drop while the four-line mode is active.
                          status_register_two <= {pay1_q[7:2], pay1_q[1] | quad_mode_q, pay1_q[0]};
                        end
                      end
                    end
                  end
                  default: begin
                    if (is_write_op(cur_op_q) && status_register_one[`SR1_WEL] && !powerup_inhibit) begin
                      if (is_array_op(cur_op_q) && target_protected) begin
                        status_register_one[`SR1_WEL] <= 1'b0;
                      end else begin
                        status_register_one[`SR1_BUSY] <= 1'b1;
                        wip_q <= 1'b1;
                        write_op_q <= 1'b1;
                        state_q <= ST_OP;
                        op_cnt_q <= OP_CYCLES - 1;
                      end
                    end
                  end
                endcase
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule // flash_guard

/* File: sim/flash_guard_chk.sv */
// Purpose: Port assertions for flash_guard.
// Assumes: One sys_clk domain, rst_n async low.
// Notes: Counters cover windows too long to unroll.
`timescale 1ns/10ps
`include "flash_guard_consts.vh"
module flash_guard_chk #(
  parameter POWERUP_CYCLES = 50,
  parameter OP_CYCLES = 10
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Pin and configuration
  input wire shared_pin_n,
  input wire hold_reset_select,
  // Status
  input wire [7:0] status_register_one,
  input wire [7:0] status_register_two,
  input wire write_op_q,
  input wire op_abort_q,
  input wire power_down_q,
  input wire reset_busy_q
);
  wire busy = status_register_one[0];
  wire write_enable_latch = status_register_one[1];
  wire pin_rst = hold_reset_select && !status_register_two[1] && !shared_pin_n;
  reg [31:0] up_cnt_q;
  reg [15:0] rb_cnt_q;
  reg [7:0] low_cnt_q;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      up_cnt_q <= 32'h0;
      rb_cnt_q <= 16'h0;
      low_cnt_q <= 8'h0;
    end else begin
      if (up_cnt_q < POWERUP_CYCLES)
        up_cnt_q <= up_cnt_q + 32'h1;
      rb_cnt_q <= reset_busy_q ? rb_cnt_q + 16'h1 : 16'h0;
      low_cnt_q <= (pin_rst && low_cnt_q != 8'hFF) ? low_cnt_q + 8'h1 : 8'h0;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_cleared;
    !write_op_q && !busy && !write_enable_latch;
  endsequence
  sequence s_busy_run;
    busy [*8];
  endsequence
  a_powerup_inhibit: assert property (up_cnt_q < POWERUP_CYCLES - 2 |-> !write_enable_latch)
    else $error("latch set in powerup window");
  a_soft_reset_block: assert property (reset_busy_q |=> !$rose(write_enable_latch))
    else $error("instruction taken in soft reset");
  a_soft_reset_time: assert property ($fell(reset_busy_q) |->
    rb_cnt_q >= `SOFT_RESET_CYCLES - 3 && rb_cnt_q <= `SOFT_RESET_CYCLES + 3)
    else $error("soft reset length off");
  a_pdown_block: assert property (power_down_q |=> !$rose(write_enable_latch))
    else $error("instruction taken in power-down");
  a_pin_reset_hold: assert property (low_cnt_q > 8'h18 |-> s_cleared)
    else $error("pin reset did not clear state");
  a_abort_pulse: assert property (op_abort_q |-> $past(write_op_q) ##1 !op_abort_q)
    else $error("abort pulse without running write");
  a_abort_clears: assert property (op_abort_q |-> ##[0:1] s_cleared)
    else $error("abort left write running");
  a_quad_no_reset: assert property (status_register_two[1] && $past(status_register_two[1], 4) |-> !op_abort_q)
    else $error("reset pin acted with quad enabled");
  a_pause_no_abort: assert property (!hold_reset_select && !$past(hold_reset_select, 4) |-> !op_abort_q)
    else $error("pause pin acted as reset");
  a_write_needs_latch: assert property ($rose(busy) |-> $past(write_enable_latch))
    else $error("write started without latch");
  a_busy_span: assert property ($rose(busy) |-> s_busy_run ##[1:400] !busy)
    else $error("busy span wrong");
  a_done_clears_latch: assert property ($fell(busy) |-> ##[0:1] !write_enable_latch)
    else $error("latch kept after write");
endmodule // flash_guard_chk
bind flash_guard flash_guard_chk #(.POWERUP_CYCLES(POWERUP_CYCLES), .OP_CYCLES(OP_CYCLES)) chk_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .shared_pin_n(shared_pin_n), .hold_reset_select(hold_reset_select),
  .status_register_one(status_register_one), .status_register_two(status_register_two),
  .write_op_q(write_op_q), .op_abort_q(op_abort_q), .power_down_q(power_down_q), .reset_busy_q(reset_busy_q));

/* File: sim/flash_host.sv */
// Purpose: Host model sending instruction frames over the link.
// Assumes: Mode 0, link clock of 400 ns built from sys_clk.
// Notes: Link clock stands low between frames; released lines flip.
`timescale 1ns/10ps
module flash_host (
  // Clock
  input wire sys_clk,
  // Link
  output reg sck,
  output reg cs_n,
  output reg [3:0] io_out
);
  reg quad = 1'b0;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    io_out = 4'h0;
  end
  task tick(input integer n);
    begin
      repeat (n) @(posedge sys_clk);
      #2;
    end
  endtask
  // One instruction per frame, so a reset pair is always two frames.
  task frame(input [23:0] d, input integer nbits);
    integer i;
    begin
      cs_n = 1'b0;
      tick(4);
      for (i = 23; i > 23 - nbits; i = i - (quad ? 4 : 1)) begin
        io_out = quad ? d[i -: 4] : {io_out[3:1], d[i]};
        tick(4);
        sck = 1'b1;
        tick(4);
        sck = 1'b0;
      end
      tick(4);
      cs_n = 1'b1;
      io_out = ~io_out;
      tick(8);
    end
  endtask
endmodule // flash_host

/* File: sim/tb_flash_guard.sv */
// Purpose: Self-checking bench for flash_guard.
// Assumes: 20 MHz sys_clk, host model drives the link.
// Notes: Short powerup and op counts keep the run brief.
`timescale 1ns/10ps
`include "flash_guard_consts.vh"
module tb_flash_guard;
  localparam PU = 200;
  localparam OPC = 150;
  reg sys_clk = 1'b0;
  reg rst_n = 1'b0;
  reg wp_n = 1'b1;
  reg pin_n = 1'b1;
  reg hold_reset_select = 1'b0;
  reg target_protected = 1'b0;
  reg abort_seen = 1'b0;
  wire sck;
  wire cs_n;
  wire [3:0] io;
  wire [7:0] sr1;
  wire [7:0] sr2;
  wire write_op, op_abort, quad_mode, power_down, reset_busy;
  integer n_fail = 0;
  integer tests_run = 0;
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (op_abort) abort_seen <= 1'b1;
  flash_host host (.sys_clk(sys_clk), .sck(sck), .cs_n(cs_n), .io_out(io));
  flash_guard #(.POWERUP_CYCLES(PU), .OP_CYCLES(OPC)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .io_in(io), .wp_n(wp_n),
    .shared_pin_n(pin_n), .hold_reset_select(hold_reset_select), .target_protected(target_protected),
    .status_register_one(sr1), .status_register_two(sr2), .write_op_q(write_op), .op_abort_q(op_abort),
    .quad_mode_q(quad_mode), .power_down_q(power_down), .reset_busy_q(reset_busy));
  task close_out;
    begin
      if (n_fail == 0 && tests_run > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task check(input [7:0] got, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        n_fail = n_fail + 1;
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge sys_clk);
      #2;
    end
  endtask
  task op(input [7:0] c);
    host.frame({c, 16'h0000}, 8);
  endtask
  task wrsr(input [7:0] a, input [7:0] b);
    host.frame({`OP_WRSR, a, b}, 24);
  endtask
  // Bounded wait for busy (sel 0) or soft reset (sel 1) to end.
  task wait_low(input integer sel, input integer lim);
    integer i;
    begin
      i = 0;
      while ((sel ? reset_busy : sr1[0]) !== 1'b0 && i < lim) begin
        cyc(1);
        i = i + 1;
      end
      if (i == lim) begin
        n_fail = n_fail + 1;
        close_out;
      end
      cyc(2);
    end
  endtask
  task t_latch;
    begin
      check(sr1, `SR1_RESET);
      check(sr2, `SR2_RESET);
      op(`OP_WREN);
      check(sr1, 8'h00);
      cyc(PU);
      op(`OP_PP);
      check(sr1, 8'h00);
      op(`OP_WREN);
      check(sr1, 8'h02);
      op(`OP_WRDI);
      check(sr1, 8'h00);
    end
  endtask
  task t_program;
    begin
      op(`OP_WREN);
      op(`OP_PP);
      check({5'h00, write_op, sr1[1:0]}, 8'h07);
      op(`OP_WRDI);
      check(sr1, 8'h03);
      wait_low(0, 300);
      check(sr1, 8'h00);
      op(`OP_WREN);
      op(`OP_PP);
      op(`OP_SUSPEND);
      check({5'h00, write_op, sr1[1:0]}, 8'h00);
      target_protected = 1'b1;
      op(`OP_WREN);
      op(`OP_SE);
      check(sr1, 8'h00);
      target_protected = 1'b0;
    end
  endtask
  task t_status;
    begin
      op(`OP_WREN);
      wrsr(8'hFC, 8'h40);
      wait_low(0, 300);
      check(sr1, 8'hFC);
      check(sr2, 8'h40);
      wp_n = 1'b0;
      op(`OP_WREN);
      wrsr(8'h00, 8'h00);
      check(sr1 & 8'hFD, 8'hFC);
      wp_n = 1'b1;
      op(`OP_WREN);
      wrsr(8'h00, 8'h00);
      wait_low(0, 300);
      check(sr1, 8'h00);
      check(sr2, 8'h00);
    end
  endtask
  task t_soft;
    begin
      op(`OP_WREN);
      op(`OP_RSTEN);
      op(`OP_RDSR1);
      op(`OP_RST);
      check({7'h00, reset_busy}, 8'h00);
      op(`OP_WRDI);
      op(`OP_RSTEN);
      op(`OP_RST);
      check({7'h00, reset_busy}, 8'h01);
      op(`OP_WREN);
      check(sr1, 8'h00);
      wait_low(1, 700);
      check(sr1, 8'h00);
      cyc(PU);
    end
  endtask
  task t_quad;
    begin
      op(`OP_WREN);
      wrsr(8'h00, 8'h02);
      wait_low(0, 300);
      op(`OP_QPI_ON);
      check({7'h00, quad_mode}, 8'h01);
      host.quad = 1'b1;
      hold_reset_select = 1'b1;
      pin_n = 1'b0;
      op(`OP_WREN);
      check(sr1, 8'h02);
      pin_n = 1'b1;
      op(`OP_RSTEN);
      op(`OP_RST);
      check({7'h00, reset_busy}, 8'h01);
      wait_low(1, 700);
      host.quad = 1'b0;
      check({7'h00, quad_mode}, 8'h00);
      cyc(PU);
      op(`OP_WREN);
      wrsr(8'h00, 8'h00);
      wait_low(0, 300);
    end
  endtask
  task t_pins;
    begin
      op(`OP_WREN);
      op(`OP_PP);
      pin_n = 1'b0;
      // The frame keeps the pin low for about 4 us, above the minimum width.
      op(`OP_WREN);
      check({5'h00, abort_seen, sr1[1:0]}, 8'h04);
      pin_n = 1'b1;
      cyc(PU);
      hold_reset_select = 1'b0;
      op(`OP_WREN);
      op(`OP_PP);
      pin_n = 1'b0;
      cyc(40);
      check(sr1, 8'h03);
      pin_n = 1'b1;
      wait_low(0, 300);
      op(`OP_PDOWN);
      op(`OP_WREN);
      check({6'h00, power_down, sr1[1]}, 8'h02);
      op(`OP_RELPD);
      op(`OP_WREN);
      check({6'h00, power_down, sr1[1]}, 8'h01);
    end
  endtask
  initial begin
    cyc(20);
    rst_n = 1'b1;
    t_latch;
    t_program;
    t_status;
    t_soft;
    t_quad;
    t_pins;
    close_out;
  end
endmodule // tb_flash_guard
